// ===== tx_chain_cfg_pkg.sv
package tx_chain_cfg_pkg;

   // ------------------------------------------------------------------
   // Register addresses.
   // ------------------------------------------------------------------
   localparam logic [11:0] ADDR_READOUT = 12'h100;
   localparam logic [11:0] ADDR_PAT_COL = 12'h104;
   localparam logic [11:0] ADDR_LPBK_PTR = 12'h105;
   localparam logic [11:0] ADDR_INTERP = 12'h106;
   localparam logic [11:0] ADDR_MIXER = 12'h107;
   localparam logic [11:0] ADDR_DIV_ROUTE = 12'h108;
   localparam logic [11:0] ADDR_PTR_STORE = 12'h141;

   // ------------------------------------------------------------------
   // Reset values.
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_PAT_COL = 8'h10;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // ------------------------------------------------------------------
   // Field positions.
   // ------------------------------------------------------------------
   localparam int BIT_READOUT = 0;
   localparam int BIT_PAT_A = 5;
   localparam int BIT_PAT_B = 6;
   localparam int BIT_TWO_AWAY_MASK = 7;
   localparam int BIT_LPBK_SEL = 0;
   localparam int BIT_LPBK_QUAL = 1;
   localparam int BIT_PTR_STORE = 3;
   localparam int POS_INTERP = 0;
   localparam int BIT_INTERP_QUAL = 2;
   localparam int BIT_F1_HP_A = 3;
   localparam int BIT_F2_HP_A = 4;
   localparam int BIT_F1_HP_B = 5;
   localparam int BIT_F2_HP_B = 6;
   localparam int BIT_MIX_EN = 0;
   localparam int POS_MIX_MODE = 1;
   localparam int BIT_MIX_STEP = 3;
   localparam int POS_MIX_PHASE = 4;
   localparam int POS_ROUTE = 1;
   localparam int POS_DIV_PHASE = 3;
   localparam int BIT_DIV_STEP = 5;
   localparam int BIT_SINC_EN = 6;
   localparam int BIT_SINC_QUAL = 7;
   localparam int POS_PTR_RD = 0;
   localparam int POS_PTR_WR = 4;

   // ------------------------------------------------------------------
   // Serial frame, samples and codes.
   // ------------------------------------------------------------------
   localparam int SPI_ADDR_BITS = 12;
   localparam int SPI_FRAME_BITS = 20;
   localparam int SAMPLE_BITS = 12;
   localparam int PATTERN_DEPTH = 8;
   localparam logic [11:0] MID_CODE = 12'h800;
   localparam logic [1:0] DIV_LAST_X1 = 2'h0;
   localparam logic [1:0] DIV_LAST_X2 = 2'h1;
   localparam logic [1:0] DIV_LAST_X4 = 2'h3;
   localparam logic [1:0] ROUTE_NORMAL = 2'h0;
   localparam logic [1:0] ROUTE_BOTH_A = 2'h1;
   localparam logic [1:0] ROUTE_BOTH_B = 2'h2;

endpackage : tx_chain_cfg_pkg

// ===== tx_chain_config_bank.sv
`timescale 1ns/100ps

module tx_chain_config_bank #(
   parameter int SAMPLE_W = tx_chain_cfg_pkg::SAMPLE_BITS
) (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // Serial programming pins.
   input wire logic spi_sen_n_i,
   input wire logic spi_sclk_i,
   input wire logic spi_sdata_i,
   output logic spi_sdout_o,
   output logic spi_sdout_oe_o,
   // Sync pin and sync-control levels.
   input wire logic sync_pin_i,
   input wire logic global_sync_disable_i,
   input wire logic mixer_sync_disable_i,
   input wire logic divider_sync_disable_i,
   // FIFO status.
   input wire logic collision_enable_i,
   input wire logic collision_other_i,
   input wire logic two_away_i,
   input wire logic [2:0] fifo_rd_ptr_i,
   input wire logic [2:0] fifo_wr_ptr_i,
   // Sample sources.
   input wire logic [SAMPLE_W-1:0] fifo_data_a_i,
   input wire logic [SAMPLE_W-1:0] fifo_data_b_i,
   input wire logic [SAMPLE_W-1:0] rx_data_a_i,
   input wire logic [SAMPLE_W-1:0] rx_data_b_i,
   input wire logic [8*SAMPLE_W-1:0] pattern_a_i,
   input wire logic [8*SAMPLE_W-1:0] pattern_b_i,
   // Converter samples.
   output logic [SAMPLE_W-1:0] dac_a_o,
   output logic [SAMPLE_W-1:0] dac_b_o,
   // Chain configuration.
   output logic sample_en_o,
   output logic [1:0] divider_phase_o,
   output logic first_filter_on_o,
   output logic second_filter_on_o,
   output logic [3:0] filter_highpass_o,
   output logic coarse_mixer_enable_o,
   output logic [1:0] coarse_mixer_mode_o,
   output logic [1:0] coarse_mixer_phase_o,
   output logic inverse_sinc_on_o
);

   // ------------------------------------------------------------------
   // Pin synchronisers.
   // ------------------------------------------------------------------
   localparam int P_SEN = 0;
   localparam int P_SCLK = 1;
   localparam int P_SDATA = 2;
   localparam int P_SYNC = 3;

   logic [3:0] pin_meta_q;
   logic [3:0] pin_q;
   logic sclk_prev_q;
   logic sync_prev_q;

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_meta_q <= 4'h1;
         pin_q <= 4'h1;
         sclk_prev_q <= 1'b0;
         sync_prev_q <= 1'b0;
      end else begin
         pin_meta_q <= {sync_pin_i, spi_sdata_i, spi_sclk_i, spi_sen_n_i};
         pin_q <= pin_meta_q;
         sclk_prev_q <= pin_q[P_SCLK];
         sync_prev_q <= pin_q[P_SYNC];
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic sync_rise;
   assign sclk_rise = pin_q[P_SCLK] & ~sclk_prev_q & ~pin_q[P_SEN];
   assign sclk_fall = ~pin_q[P_SCLK] & sclk_prev_q & ~pin_q[P_SEN];
   assign sync_rise = pin_q[P_SYNC] & ~sync_prev_q;

   // ------------------------------------------------------------------
   // Serial frame receiver.
   // ------------------------------------------------------------------
   logic [18:0] shift_in_q;
   logic [4:0] bit_cnt_q;
   logic [7:0] sdout_q;
   logic [19:0] frame;
   logic frame_done;
   logic addr_done;
   logic [11:0] early_addr;
   logic readout_q;

   assign frame = {shift_in_q, pin_q[P_SDATA]};
   assign frame_done = sclk_rise && bit_cnt_q == 5'(tx_chain_cfg_pkg::SPI_FRAME_BITS - 1);
   assign addr_done = sclk_rise && bit_cnt_q == 5'(tx_chain_cfg_pkg::SPI_ADDR_BITS - 1);
   assign early_addr = frame[11:0];

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         shift_in_q <= '0;
         bit_cnt_q <= '0;
      end else if (pin_q[P_SEN]) begin
         bit_cnt_q <= '0;
      end else if (sclk_rise) begin
         shift_in_q <= frame[18:0];
         if (bit_cnt_q != 5'(tx_chain_cfg_pkg::SPI_FRAME_BITS)) begin
            bit_cnt_q <= bit_cnt_q + 5'h1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Configuration registers.
   // ------------------------------------------------------------------
   logic [7:0] pat_col_q;
   logic [7:0] lpbk_ptr_q;
   logic [7:0] interp_q;
   logic [7:0] mixer_q;
   logic [7:0] div_route_q;
   logic [7:0] ptr_store_q;
   logic wr_en;

   // In readout mode only the readout bit itself can still be written.
   assign wr_en = frame_done && (!readout_q || frame[19:8] == tx_chain_cfg_pkg::ADDR_READOUT);

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         readout_q <= 1'b0;
         pat_col_q <= tx_chain_cfg_pkg::RST_PAT_COL;
         lpbk_ptr_q <= tx_chain_cfg_pkg::RST_ZERO;
         interp_q <= tx_chain_cfg_pkg::RST_ZERO;
         mixer_q <= tx_chain_cfg_pkg::RST_ZERO;
         div_route_q <= tx_chain_cfg_pkg::RST_ZERO;
      end else if (wr_en) begin
         unique case (frame[19:8])
            tx_chain_cfg_pkg::ADDR_READOUT: readout_q <= frame[tx_chain_cfg_pkg::BIT_READOUT];
            tx_chain_cfg_pkg::ADDR_PAT_COL: pat_col_q <= frame[7:0];
            tx_chain_cfg_pkg::ADDR_LPBK_PTR: lpbk_ptr_q <= frame[7:0];
            tx_chain_cfg_pkg::ADDR_INTERP: interp_q <= frame[7:0];
            tx_chain_cfg_pkg::ADDR_MIXER: mixer_q <= frame[7:0];
            tx_chain_cfg_pkg::ADDR_DIV_ROUTE: div_route_q <= frame[7:0];
            default: ;
         endcase
      end
   end

   function automatic logic [7:0] read_reg(input logic [11:0] addr);
      logic [7:0] v;
      v = 8'h00;
      unique case (addr)
         tx_chain_cfg_pkg::ADDR_READOUT: v = {7'h00, readout_q};
         tx_chain_cfg_pkg::ADDR_PAT_COL: v = pat_col_q;
         tx_chain_cfg_pkg::ADDR_LPBK_PTR: v = lpbk_ptr_q;
         tx_chain_cfg_pkg::ADDR_INTERP: v = interp_q;
         tx_chain_cfg_pkg::ADDR_MIXER: v = mixer_q;
         tx_chain_cfg_pkg::ADDR_DIV_ROUTE: v = div_route_q;
         tx_chain_cfg_pkg::ADDR_PTR_STORE: v = ptr_store_q;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : read_reg

   // ------------------------------------------------------------------
   // Readout shifter: MSB after the address, one bit per falling edge.
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sdout_q <= '0;
      end else if (addr_done && readout_q) begin
         sdout_q <= read_reg(early_addr);
      end else if (sclk_fall && bit_cnt_q > 5'(tx_chain_cfg_pkg::SPI_ADDR_BITS)) begin
         sdout_q <= {sdout_q[6:0], 1'b0};
      end
   end

   assign spi_sdout_o = sdout_q[7];
   assign spi_sdout_oe_o = readout_q & ~pin_q[P_SEN];

   // ------------------------------------------------------------------
   // Field decode.
   // ------------------------------------------------------------------
   logic [1:0] interp_code;
   logic [1:0] div_last;
   logic loopback_on;
   logic mixer_step_q;
   logic div_step_q;
   logic mixer_step_rise;
   logic div_step_rise;
   logic mixer_sync;
   logic divider_sync;

   assign interp_code = interp_q[tx_chain_cfg_pkg::BIT_INTERP_QUAL]
      ? interp_q[tx_chain_cfg_pkg::POS_INTERP +: 2] : 2'h0;
   assign div_last = interp_code == 2'h0 ? tx_chain_cfg_pkg::DIV_LAST_X1 :
      interp_code == 2'h1 ? tx_chain_cfg_pkg::DIV_LAST_X2 : tx_chain_cfg_pkg::DIV_LAST_X4;
   assign first_filter_on_o = interp_code != 2'h0;
   assign second_filter_on_o = interp_code[1];
   assign filter_highpass_o = {interp_q[tx_chain_cfg_pkg::BIT_F2_HP_B],
      interp_q[tx_chain_cfg_pkg::BIT_F1_HP_B], interp_q[tx_chain_cfg_pkg::BIT_F2_HP_A],
      interp_q[tx_chain_cfg_pkg::BIT_F1_HP_A]};
   assign loopback_on = lpbk_ptr_q[tx_chain_cfg_pkg::BIT_LPBK_SEL]
      & lpbk_ptr_q[tx_chain_cfg_pkg::BIT_LPBK_QUAL];
   assign coarse_mixer_enable_o = mixer_q[tx_chain_cfg_pkg::BIT_MIX_EN];
   assign coarse_mixer_mode_o = coarse_mixer_enable_o
      ? mixer_q[tx_chain_cfg_pkg::POS_MIX_MODE +: 2] : 2'h0;
   assign inverse_sinc_on_o = div_route_q[tx_chain_cfg_pkg::BIT_SINC_EN]
      & div_route_q[tx_chain_cfg_pkg::BIT_SINC_QUAL];

   // A sync edge reaches a block globally, or through its own path when global sync is off.
   assign mixer_sync = sync_rise & (~global_sync_disable_i | ~mixer_sync_disable_i);
   assign divider_sync = sync_rise & (~global_sync_disable_i | ~divider_sync_disable_i);
   assign mixer_step_rise = mixer_q[tx_chain_cfg_pkg::BIT_MIX_STEP] & ~mixer_step_q
      & global_sync_disable_i & mixer_sync_disable_i;
   assign div_step_rise = div_route_q[tx_chain_cfg_pkg::BIT_DIV_STEP] & ~div_step_q
      & global_sync_disable_i & divider_sync_disable_i;

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mixer_step_q <= 1'b0;
         div_step_q <= 1'b0;
      end else begin
         mixer_step_q <= mixer_q[tx_chain_cfg_pkg::BIT_MIX_STEP];
         div_step_q <= div_route_q[tx_chain_cfg_pkg::BIT_DIV_STEP];
      end
   end

   // ------------------------------------------------------------------
   // Interpolation clock divider and mixer phase.
   // ------------------------------------------------------------------
   logic [1:0] div_cnt_q;
   logic [1:0] mix_phase_q;

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div_cnt_q <= 2'h0;
      end else if (divider_sync) begin
         div_cnt_q <= div_route_q[tx_chain_cfg_pkg::POS_DIV_PHASE +: 2] & div_last;
      end else if (div_step_rise) begin
         div_cnt_q <= (div_cnt_q + 2'h2) & div_last;
      end else begin
         div_cnt_q <= (div_cnt_q + 2'h1) & div_last;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mix_phase_q <= 2'h0;
      end else if (mixer_sync) begin
         mix_phase_q <= mixer_q[tx_chain_cfg_pkg::POS_MIX_PHASE +: 2];
      end else if (mixer_step_rise) begin
         mix_phase_q <= mix_phase_q + 2'h2;
      end else begin
         mix_phase_q <= mix_phase_q + 2'h1;
      end
   end

   assign sample_en_o = div_cnt_q == 2'h0;
   assign divider_phase_o = div_cnt_q;
   assign coarse_mixer_phase_o = mix_phase_q;

   // ------------------------------------------------------------------
   // Pointer capture.
   // ------------------------------------------------------------------
   logic ptr_capture;
   assign ptr_capture = sample_en_o & lpbk_ptr_q[tx_chain_cfg_pkg::BIT_PTR_STORE] & ~readout_q;

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ptr_store_q <= tx_chain_cfg_pkg::RST_ZERO;
      end else if (ptr_capture) begin
         ptr_store_q <= '0;
         ptr_store_q[tx_chain_cfg_pkg::POS_PTR_RD +: 3] <= fifo_rd_ptr_i;
         ptr_store_q[tx_chain_cfg_pkg::POS_PTR_WR +: 3] <= fifo_wr_ptr_i;
      end
   end

   // ------------------------------------------------------------------
   // Sample path: source, pattern, collision, routing.
   // ------------------------------------------------------------------
   logic [2:0] pat_idx_a_q;
   logic [2:0] pat_idx_b_q;
   logic force_mid;
   logic [SAMPLE_W-1:0] chain_a;
   logic [SAMPLE_W-1:0] chain_b;

   assign force_mid = collision_enable_i & (collision_other_i
      | (two_away_i & ~pat_col_q[tx_chain_cfg_pkg::BIT_TWO_AWAY_MASK]));

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pat_idx_a_q <= 3'h0;
         pat_idx_b_q <= 3'h0;
      end else begin
         if (!pat_col_q[tx_chain_cfg_pkg::BIT_PAT_A]) begin
            pat_idx_a_q <= 3'h0;
         end else if (sample_en_o) begin
            pat_idx_a_q <= pat_idx_a_q + 3'h1;
         end
         if (!pat_col_q[tx_chain_cfg_pkg::BIT_PAT_B]) begin
            pat_idx_b_q <= 3'h0;
         end else if (sample_en_o) begin
            pat_idx_b_q <= pat_idx_b_q + 3'h1;
         end
      end
   end

   always_comb begin
      chain_a = loopback_on ? rx_data_a_i : fifo_data_a_i;
      chain_b = loopback_on ? rx_data_b_i : fifo_data_b_i;
      if (pat_col_q[tx_chain_cfg_pkg::BIT_PAT_A]) begin
         chain_a = pattern_a_i[pat_idx_a_q * SAMPLE_W +: SAMPLE_W];
      end
      if (pat_col_q[tx_chain_cfg_pkg::BIT_PAT_B]) begin
         chain_b = pattern_b_i[pat_idx_b_q * SAMPLE_W +: SAMPLE_W];
      end
      if (force_mid) begin
         chain_a = tx_chain_cfg_pkg::MID_CODE;
         chain_b = tx_chain_cfg_pkg::MID_CODE;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dac_a_o <= tx_chain_cfg_pkg::MID_CODE;
         dac_b_o <= tx_chain_cfg_pkg::MID_CODE;
      end else if (sample_en_o) begin
         unique case (div_route_q[tx_chain_cfg_pkg::POS_ROUTE +: 2])
            tx_chain_cfg_pkg::ROUTE_NORMAL: begin
               dac_a_o <= chain_a;
               dac_b_o <= chain_b;
            end
            tx_chain_cfg_pkg::ROUTE_BOTH_A: begin
               dac_a_o <= chain_a;
               dac_b_o <= chain_a;
            end
            tx_chain_cfg_pkg::ROUTE_BOTH_B: begin
               dac_a_o <= chain_b;
               dac_b_o <= chain_b;
            end
            default: begin
               dac_a_o <= chain_b;
               dac_b_o <= chain_a;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Assertions.
   // ------------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_mid_cause;
      sample_en_o && collision_enable_i && two_away_i
         && !pat_col_q[tx_chain_cfg_pkg::BIT_TWO_AWAY_MASK];
   endsequence
   sequence s_mixer_step;
      $rose(mixer_q[tx_chain_cfg_pkg::BIT_MIX_STEP]) && global_sync_disable_i
         && mixer_sync_disable_i && !sync_rise;
   endsequence
   sequence s_div_step;
      $rose(div_route_q[tx_chain_cfg_pkg::BIT_DIV_STEP]) && global_sync_disable_i
         && divider_sync_disable_i && !sync_rise;
   endsequence

   property p_pattern_a;
      sample_en_o && pat_col_q[tx_chain_cfg_pkg::BIT_PAT_A] && !force_mid
         && div_route_q[2:1] == 2'h0
      |=> dac_a_o == $past(pattern_a_i[pat_idx_a_q * SAMPLE_W +: SAMPLE_W]);
   endproperty
   a_pattern_a: assert property (p_pattern_a) else $error("pattern A sample wrong");

   property p_pattern_b;
      sample_en_o && pat_col_q[tx_chain_cfg_pkg::BIT_PAT_B]
      |=> pat_idx_b_q == $past(pat_idx_b_q) + 3'h1;
   endproperty
   a_pattern_b: assert property (p_pattern_b) else $error("pattern B index stuck");

   property p_two_away;
      s_mid_cause |=> dac_a_o == tx_chain_cfg_pkg::MID_CODE && dac_b_o == tx_chain_cfg_pkg::MID_CODE;
   endproperty
   a_two_away: assert property (p_two_away) else $error("two-away not forced to mid");

   property p_ptr_store;
      ptr_capture |=> ptr_store_q[2:0] == $past(fifo_rd_ptr_i)
         && ptr_store_q[6:4] == $past(fifo_wr_ptr_i);
   endproperty
   a_ptr_store: assert property (p_ptr_store) else $error("pointers not stored");

   property p_ptr_hold;
      readout_q |=> $stable(ptr_store_q);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointers moved in readout");

   property p_loopback;
      sample_en_o && loopback_on && !force_mid && pat_col_q[6:5] == 2'h0
         && div_route_q[2:1] == 2'h0
      |=> dac_a_o == $past(rx_data_a_i) && dac_b_o == $past(rx_data_b_i);
   endproperty
   a_loopback: assert property (p_loopback) else $error("loopback path wrong");

   property p_interp;
      interp_code[1] |-> div_last == 2'h3 && first_filter_on_o && second_filter_on_o;
   endproperty
   a_interp: assert property (p_interp) else $error("factor 4 decode wrong");

   property p_mixer_mode;
      !mixer_q[tx_chain_cfg_pkg::BIT_MIX_EN] |-> coarse_mixer_mode_o == 2'h0;
   endproperty
   a_mixer_mode: assert property (p_mixer_mode) else $error("mixer mode while off");

   property p_mixer_step;
      s_mixer_step |-> ##1 mix_phase_q == 2'($past(mix_phase_q) + 2'h2);
   endproperty
   a_mixer_step: assert property (p_mixer_step) else $error("mixer step missed");

   property p_mixer_sync;
      mixer_sync |=> mix_phase_q == $past(mixer_q[5:4]) ##1 mix_phase_q == 2'($past(mixer_q[5:4]) + 2'h1);
   endproperty
   a_mixer_sync: assert property (p_mixer_sync) else $error("mixer sync phase wrong");

   property p_div_step;
      s_div_step |=> div_cnt_q == (2'($past(div_cnt_q) + 2'h2) & $past(div_last));
   endproperty
   a_div_step: assert property (p_div_step) else $error("divider step missed");

   property p_div_sync;
      divider_sync |=> div_cnt_q == ($past(div_route_q[4:3]) & $past(div_last));
   endproperty
   a_div_sync: assert property (p_div_sync) else $error("divider sync phase wrong");

   property p_sinc;
      inverse_sinc_on_o |-> div_route_q[7] && div_route_q[6];
   endproperty
   a_sinc: assert property (p_sinc) else $error("sinc on without qualifier");

endmodule : tx_chain_config_bank

// ===== spi_host_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Host that frames serial transfers with slow clock phases.
// ---------------------------------------------------------------
module spi_host_model (
   // Clock and readout data.
   input wire logic core_clk_i,
   input wire logic spi_sdout_i,
   // Serial programming pins.
   output logic spi_sen_n_o,
   output logic spi_sclk_o,
   output logic spi_sdata_o
);
   initial begin
      spi_sen_n_o = 1'b1;
      spi_sclk_o = 1'b0;
      spi_sdata_o = 1'b0;
   end
   // Readout bits are taken just before rises 13 to 20.
   task automatic xfer(input logic [19:0] frame, output logic [7:0] rd);
      rd = 8'h00;
      @(posedge core_clk_i);
      #1 spi_sen_n_o = 1'b0;
      for (int i = 19; i >= 0; i--) begin
         spi_sclk_o = 1'b0;
         spi_sdata_o = frame[i];
         repeat (6) @(posedge core_clk_i);
         if (i < 8) rd[i] = spi_sdout_i;
         #1 spi_sclk_o = 1'b1;
         repeat (5) @(posedge core_clk_i);
         #1;
      end
      spi_sclk_o = 1'b0;
      spi_sdata_o = ~frame[0];
      repeat (5) @(posedge core_clk_i);
      #1 spi_sen_n_o = 1'b1;
      repeat (4) @(posedge core_clk_i);
      #1;
   endtask : xfer
endmodule : spi_host_model

// ===== tx_chain_config_bank_bench.sv
`timescale 1ns/100ps
module tx_chain_config_bank_bench;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic sen_n, sclk, sdata, sdout, s_en, f1, f2, m_en, sinc, oe;
   logic c_en = 1'b0, two = 1'b0, syn = 1'b0, g_dis = 1'b0;
   logic [2:0] rp = 3'h0, wp = 3'h0;
   logic [11:0] fa = 12'h000, fb = 12'h000, ra = 12'h000, rb = 12'h000, da, db, x;
   logic [95:0] pa = '0, pb = '0;
   logic [1:0] m_md, mph, dph;
   logic [3:0] hp;
   logic [31:0] exp_q[$];
   logic [31:0] obs, e_v;
   logic [7:0] v;
   int err_total = 0;
   int checks_done = 0;
   int f, n, m;
   int oe_n = 0;
   event look;
   always #5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) oe_n <= oe_n + int'(oe);
   spi_host_model i_spi_host_model (.core_clk_i(core_clk_i), .spi_sdout_i(sdout),
      .spi_sen_n_o(sen_n), .spi_sclk_o(sclk), .spi_sdata_o(sdata));
   tx_chain_config_bank i_tx_chain_config_bank (.core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i), .spi_sen_n_i(sen_n), .spi_sclk_i(sclk), .spi_sdata_i(sdata),
      .spi_sdout_o(sdout), .spi_sdout_oe_o(oe), .sync_pin_i(syn),
      .global_sync_disable_i(g_dis), .mixer_sync_disable_i(g_dis),
      .divider_sync_disable_i(g_dis), .collision_enable_i(c_en), .collision_other_i(1'b0),
      .two_away_i(two), .fifo_rd_ptr_i(rp), .fifo_wr_ptr_i(wp), .fifo_data_a_i(fa),
      .fifo_data_b_i(fb), .rx_data_a_i(ra), .rx_data_b_i(rb), .pattern_a_i(pa),
      .pattern_b_i(pb), .dac_a_o(da), .dac_b_o(db), .sample_en_o(s_en),
      .divider_phase_o(dph), .first_filter_on_o(f1), .second_filter_on_o(f2),
      .filter_highpass_o(hp), .coarse_mixer_enable_o(m_en), .coarse_mixer_mode_o(m_md),
      .coarse_mixer_phase_o(mph), .inverse_sinc_on_o(sinc));
   // ---------------------------------------------------------------
   // Result queue, comparison and verdict.
   // ---------------------------------------------------------------
   task automatic note(input logic [31:0] e, input logic [31:0] g);
      exp_q.push_back(e);
      obs = g;
      ->look;
      #1;
   endtask : note
   task automatic cmp_out;
      e_v = exp_q.pop_front();
      checks_done++;
      if (obs !== e_v) begin
         err_total++;
         $display("BAD t=%0t exp=%h got=%h", $time, e_v, obs);
      end
   endtask : cmp_out
   always @(look) cmp_out();
   task automatic give_verdict;
      if (err_total == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (60000) @(posedge core_clk_i);
      err_total++;
      give_verdict();
   end
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] q;
      i_spi_host_model.xfer({a, d}, q);
   endtask : wr
   // Enters readout mode, reads one place and leaves readout mode.
   task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
      logic [7:0] d;
      wr(tx_chain_cfg_pkg::ADDR_READOUT, 8'h01);
      m = oe_n;
      i_spi_host_model.xfer({a, 8'h00}, d);
      m = oe_n - m;
      wr(tx_chain_cfg_pkg::ADDR_READOUT, 8'h00);
      note({24'h0, e}, {24'h0, d});
      note(32'h0000_00e1, 32'(m));
   endtask : rdchk
   task automatic settle;
      repeat (4) @(posedge core_clk_i);
      #1;
   endtask : settle
   // ---------------------------------------------------------------
   // Main sequence.
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'hb63f_f6e3));
      {fa, fb, ra, rb} = 48'({$urandom, $urandom});
      pa = {$urandom, $urandom, $urandom};
      pb = {$urandom, $urandom, $urandom};
      repeat (10) @(posedge core_clk_i);
      #1 sys_rst_i = 1'b0;
      repeat (3) @(posedge core_clk_i);
      for (logic [11:0] a = 12'h104; a <= 12'h109; a++) rdchk(a, (a == 12'h104) ? 8'h10 : 8'h00);
      wr(tx_chain_cfg_pkg::ADDR_READOUT, 8'h01);
      wr(tx_chain_cfg_pkg::ADDR_INTERP, 8'h55);
      rdchk(tx_chain_cfg_pkg::ADDR_INTERP, 8'h00);
      for (logic [11:0] a = 12'h104; a <= 12'h108; a++) begin
         v = 8'($urandom);
         wr(a, v);
         rdchk(a, v);
         wr(a, 8'h00);
      end
      for (int i = 0; i < 8; i++) begin
         v = {1'b0, 4'($urandom), 3'(i)};
         if (i >= 6) v[3] = 1'b0;
         f = (i < 5) ? 1 : (i == 5) ? 2 : 4;
         wr(tx_chain_cfg_pkg::ADDR_INTERP, v);
         n = 0;
         repeat (8) begin
            @(posedge core_clk_i);
            #1 n += int'(s_en);
         end
         note({22'h0, f > 1, f == 4, v[6:3], 4'(8 / f)}, {22'h0, f1, f2, hp, 4'(n)});
      end
      wr(tx_chain_cfg_pkg::ADDR_INTERP, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(tx_chain_cfg_pkg::ADDR_MIXER, 8'(i));
         note({29'h0, i[0], i[0] ? i[2:1] : 2'h0}, {29'h0, m_en, m_md});
      end
      for (int i = 0; i < 4; i++) begin
         wr(tx_chain_cfg_pkg::ADDR_DIV_ROUTE, {i[1:0], 3'h0, i[1:0], 1'b0});
         settle();
         note({31'h0, &i[1:0]}, {31'h0, sinc});
         x = i[0] ? fa : fb;
         note({8'h0, i[1] ? fb : fa, x}, {8'h0, da, db});
      end
      wr(tx_chain_cfg_pkg::ADDR_DIV_ROUTE, 8'h00);
      {c_en, two} = 2'b11;
      for (int i = 0; i < 2; i++) begin
         wr(tx_chain_cfg_pkg::ADDR_PAT_COL, i ? 8'h80 : 8'h00);
         settle();
         x = tx_chain_cfg_pkg::MID_CODE;
         note({8'h0, i ? {fa, fb} : {x, x}}, {8'h0, da, db});
      end
      {c_en, two} = 2'b00;
      for (int i = 1; i < 4; i++) begin
         wr(tx_chain_cfg_pkg::ADDR_LPBK_PTR, 8'(i));
         settle();
         note({8'h0, (i == 3) ? {ra, rb} : {fa, fb}}, {8'h0, da, db});
      end
      for (int k = 0; k < 2; k++) begin
         wr(tx_chain_cfg_pkg::ADDR_PAT_COL, 8'h20 << k);
         e_v = 32'h0;
         for (int j = 0; j < 8; j++) e_v[11:0] ^= k ? pb[12*j +: 12] : pa[12*j +: 12];
         x = 12'h000;
         repeat (8) begin
            @(posedge core_clk_i);
            #1 x ^= k ? db : da;
         end
         note(e_v, {20'h0, x});
      end
      wr(tx_chain_cfg_pkg::ADDR_PAT_COL, 8'h00);
      wr(tx_chain_cfg_pkg::ADDR_LPBK_PTR, 8'h08);
      {rp, wp} = 6'($urandom);
      v = {1'b0, wp, 1'b0, rp};
      settle();
      wr(tx_chain_cfg_pkg::ADDR_READOUT, 8'h01);
      {rp, wp} = ~{rp, wp};
      rdchk(tx_chain_cfg_pkg::ADDR_PTR_STORE, v);
      wr(tx_chain_cfg_pkg::ADDR_INTERP, 8'h06);
      wr(tx_chain_cfg_pkg::ADDR_MIXER, 8'h31);
      wr(tx_chain_cfg_pkg::ADDR_DIV_ROUTE, 8'h10);
      syn = 1'b1;
      repeat (3) @(posedge core_clk_i);
      #1 note(32'h0000_0032, {24'h0, 2'h0, mph, 2'h0, dph});
      syn = 1'b0;
      g_dis = 1'b1;
      v = {4'h0, mph, dph};
      n = int'($time / 10);
      wr(tx_chain_cfg_pkg::ADDR_MIXER, 8'h39);
      wr(tx_chain_cfg_pkg::ADDR_DIV_ROUTE, 8'h30);
      n = int'($time / 10) - n + 1;
      note({28'h0, 2'(v[3:2] + n), 2'(v[1:0] + n)}, {28'h0, mph, dph});
      give_verdict();
   end
endmodule : tx_chain_config_bank_bench
